// ===== logic/bfr_consts.svh
/*
 * Constants of the breaker-failure timer block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef BFR_CONSTS_SVH
`define BFR_CONSTS_SVH

// ==========================================================================
// Timing
`define BFR_CLK_NS        100
`define BFR_STEP_MS       10
`define BFR_TICK_CYCLES   ((`BFR_STEP_MS * 1000000) / `BFR_CLK_NS)
`define BFR_PRE_W         24

// ==========================================================================
// Register offsets (byte addresses)
`define BFR_ADDR_W        8
`define BFR_DATA_W        16
`define BFR_OFS_CTRL      8'h00
`define BFR_OFS_DLY1      8'h04
`define BFR_OFS_DLY2      8'h08
`define BFR_OFS_UCPH      8'h0c
`define BFR_OFS_UCSEF     8'h10
`define BFR_OFS_STATUS    8'h14

// ==========================================================================
// Control fields and reset values
`define BFR_CTRL_EN1      0
`define BFR_CTRL_EN2      1
`define BFR_CTRL_REMOC    2
`define BFR_CTRL_REMEF    3
`define BFR_CTRL_SEL_LO   4
`define BFR_CTRL_SEL_HI   5
`define BFR_CTRL_RST      16'h0001

// Delays in 10 ms steps, thresholds in their own step units
`define BFR_DLY1_RST      16'h0014
`define BFR_DLY2_RST      16'h0028
`define BFR_DLY_MAX       16'h03e8
`define BFR_UCPH_RST      16'h000a
`define BFR_UCPH_MIN      16'h0002
`define BFR_UCPH_MAX      16'h0140
`define BFR_UCSEF_RST     16'h0050
`define BFR_UCSEF_MIN     16'h0004
`define BFR_UCSEF_MAX     16'h0c80

`endif

// ===== logic/bfr_pkg.sv
/*
 * Types of the breaker-failure timer block.
 * Assumes the constants header is on the include path.
 */
`include "bfr_consts.svh"

package bfr_pkg;

	// ======================================================================
	// External initiation reset choices
	typedef enum logic [1:0] {
		BFR_EXT_UC_ONLY   = 2'h0,
		BFR_EXT_PROT_UC   = 2'h1,
		BFR_EXT_OPEN_UC   = 2'h2,
		BFR_EXT_SPARE     = 2'h3
	} bfr_ext_sel_e;

	// Delay timer state
	typedef struct packed {
		logic [15:0] count;
		logic        expired;
	} bfr_timer_s;

	// Supervisor state
	typedef struct packed {
		logic                      en1;
		logic                      en2;
		logic                      remOc;
		logic                      remEf;
		bfr_ext_sel_e              extSel;
		logic [15:0]               dly1;
		logic [15:0]               dly2;
		logic [15:0]               ucPh;
		logic [15:0]               ucSef;
		logic [`BFR_PRE_W-1:0]     prescale;
		logic                      tick;
		logic                      curInit;
		logic                      sefInit;
		logic                      extInit;
		logic                      ocStart;
		logic                      efStart;
		logic                      fail1;
		logic                      fail2;
		logic [`BFR_DATA_W-1:0]    rdData;
	} bfr_state_s;

endpackage : bfr_pkg

// ===== logic/bfr_delay_timer.sv
/*
 * One breaker-failure delay timer counting 10 ms steps.
 * Assumes a one-cycle step tick and a run level from the supervisor.
 */
`timescale 1ns/10ps
`include "bfr_consts.svh"

module bfr_delay_timer #(
	parameter int DLY_W = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             enable,
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [DLY_W-1:0] delay,
	output logic                  expired
);
	import bfr_pkg::*;

	// ======================================================================
	// Elaboration check
	if (DLY_W < 11 || DLY_W > 16)
	begin : g_bad_width
		$error("bfr_delay_timer: DLY_W must lie in 11..16");
	end

	bfr_timer_s st;
	bfr_timer_s next_st;

	// Count while running, clear at once when stopped or disabled
	always_comb
	begin
		next_st = st;
		if (!enable || !run)
		begin
			next_st.count   = 16'h0000;
			next_st.expired = 1'b0;
		end
		else if (!st.expired)
		begin
			if (st.count >= 16'(delay))
				next_st.expired = 1'b1;
			else if (tick)
				next_st.count = st.count + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign expired = st.expired;                                 // Held until cleared

endmodule : bfr_delay_timer

// ===== logic/bfr_breaker_fail.sv
/*
 * Breaker-failure supervisor: initiation latching, reset selection by
 * undercurrent, breaker-open and protection reset, two delay timers,
 * start withdrawal and a small register file on a plain port.
 * Assumes synchronous inputs on ref_clk, current magnitudes already
 * measured, and a master that never asserts both strobes together.
 */
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "bfr_consts.svh"

// Function
// - Current trips reset only when all four undercurrent
// - Sensitive earth trips reset on its undercurrent only
// - External trips use a selectable reset condition
// - Breaker open or protection reset need undercurrent
// - First timer enabled, 0 to 10 s, 0.2 s
// - Second timer disabled, same range, 0.4 s
// - Phase undercurrent threshold 0.02 to 3.2 In
// - Earth undercurrent threshold 0.001 to 0.8 In
// - Timeout withdraws starts when removal is enabled
// - Trip starts both timers; expiry raises failure
module bfr_breaker_fail #(
	parameter int TICK_CYCLES = `BFR_TICK_CYCLES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   srst,
	input  wire logic [`BFR_ADDR_W-1:0] regAddr,
	input  wire logic [`BFR_DATA_W-1:0] regWrData,
	input  wire logic                   regWr,
	input  wire logic                   regRd,
	output logic      [`BFR_DATA_W-1:0] regRdData,
	input  wire logic [15:0]            phaseAMag,
	input  wire logic [15:0]            phaseBMag,
	input  wire logic [15:0]            phaseCMag,
	input  wire logic [15:0]            neutralMag,
	input  wire logic [15:0]            sefMag,
	input  wire logic                   currentTrip,
	input  wire logic                   sefTrip,
	input  wire logic                   extTrip,
	input  wire logic [2:0]             breakerOpen,
	input  wire logic                   ocStartIn,
	input  wire logic                   efStartIn,
	output logic                        firstFailure,
	output logic                        secondFailure,
	output logic                        ocStart,
	output logic                        efStart
);
	import bfr_pkg::*;

	// ======================================================================
	// Elaboration check
	if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << `BFR_PRE_W))
	begin : g_bad_tick
		$error("bfr_breaker_fail: TICK_CYCLES out of range");
	end

	// Prescaler value on which the step tick is raised
	localparam logic [`BFR_PRE_W-1:0] PRE_LAST = `BFR_PRE_W'(TICK_CYCLES - 1);

	// ======================================================================
	// Helper functions

	// Undercurrent element operates while magnitude is below threshold
	// A magnitude sitting exactly on the threshold still counts as flowing
	function automatic logic under(input logic [15:0] mag,
	                               input logic [15:0] thr);
		under = (mag < thr);
	endfunction : under

	// Clamp a written setting into its legal range
	// A zero threshold would otherwise never let a breaker-fail reset through
	function automatic logic [15:0] clamp(input logic [15:0] v,
	                                      input logic [15:0] lo,
	                                      input logic [15:0] hi);
		if (v < lo)
			clamp = lo;
		else if (v > hi)
			clamp = hi;
		else
			clamp = v;
	endfunction : clamp

	// ======================================================================
	// State and detectors

	bfr_state_s st;
	bfr_state_s next_st;

	logic ucA;
	logic ucB;
	logic ucC;
	logic ucN;
	logic allUc;
	logic sefUc;
	logic allOpen;
	logic curReset;
	logic sefReset;
	logic extReset;
	logic active;
	logic tmr1Expired;
	logic tmr2Expired;
	logic [`BFR_DATA_W-1:0] statusWord;
	logic [`BFR_DATA_W-1:0] ctrlWord;

	// Undercurrent detectors; neutral shares the phase threshold
	assign ucA     = under(phaseAMag, st.ucPh);
	assign ucB     = under(phaseBMag, st.ucPh);
	assign ucC     = under(phaseCMag, st.ucPh);
	assign ucN     = under(neutralMag, st.ucPh);
	assign sefUc   = under(sefMag, st.ucSef);
	assign allUc   = ucA & ucB & ucC & ucN;
	assign allOpen = &breakerOpen;

	// Reset condition of each initiation source
	assign curReset = allUc;
	assign sefReset = sefUc;

	// External reset per select; the spare code acts as undercurrent only

	always_comb
	begin
		unique case (st.extSel)
			BFR_EXT_PROT_UC: extReset = ~extTrip & allUc;
			BFR_EXT_OPEN_UC: extReset = allOpen & allUc;
			default:         extReset = allUc;
		endcase
	end

	// Timers run while any source stays initiated and unreset
	assign active = st.curInit | st.sefInit | st.extInit;

	// ======================================================================
	// Delay timers
	// Both timers share one run level, so every latched source must be
	// cleared, or the timer's enable bit cleared, before its failure output can drop

	bfr_delay_timer #(
		.DLY_W (16)
	) u_first_failure_timer (
		.ref_clk (ref_clk),
		.srst    (srst),
		.enable  (st.en1),
		.run     (active),
		.tick    (st.tick),
		.delay   (st.dly1),
		.expired (tmr1Expired)
	);

	bfr_delay_timer #(
		.DLY_W (16)
	) u_second_failure_timer (
		.ref_clk (ref_clk),
		.srst    (srst),
		.enable  (st.en2),
		.run     (active),
		.tick    (st.tick),
		.delay   (st.dly2),
		.expired (tmr2Expired)
	);

	// ======================================================================
	// Register views

	// Control word as software reads it back
	always_comb
	begin
		ctrlWord                   = '0;
		ctrlWord[`BFR_CTRL_EN1]    = st.en1;
		ctrlWord[`BFR_CTRL_EN2]    = st.en2;
		ctrlWord[`BFR_CTRL_REMOC]  = st.remOc;
		ctrlWord[`BFR_CTRL_REMEF]  = st.remEf;
		ctrlWord[`BFR_CTRL_SEL_HI:`BFR_CTRL_SEL_LO] = st.extSel;
	end

	// Live status of the supervisor
	assign statusWord = {7'h00, sefUc, allUc, st.extInit, st.sefInit,
	                     st.curInit, st.efStart, st.ocStart, st.fail2,
	                     st.fail1};

	// ======================================================================
	// Next-state logic
	always_comb
	begin
		next_st = st;

		// Register writes; out-of-range settings are clamped
		// The status word is read-only, so a write to it falls to the default
		if (regWr)
		begin
			unique case (regAddr)
				`BFR_OFS_CTRL:
				begin
					next_st.en1    = regWrData[`BFR_CTRL_EN1];
					next_st.en2    = regWrData[`BFR_CTRL_EN2];
					next_st.remOc  = regWrData[`BFR_CTRL_REMOC];
					next_st.remEf  = regWrData[`BFR_CTRL_REMEF];
					next_st.extSel = bfr_ext_sel_e'(
						regWrData[`BFR_CTRL_SEL_HI:`BFR_CTRL_SEL_LO]);
				end
				`BFR_OFS_DLY1:
					next_st.dly1 = clamp(regWrData, 16'h0000,
					                     `BFR_DLY_MAX);
				`BFR_OFS_DLY2:
					next_st.dly2 = clamp(regWrData, 16'h0000,
					                     `BFR_DLY_MAX);
				`BFR_OFS_UCPH:
					next_st.ucPh = clamp(regWrData, `BFR_UCPH_MIN,
					                     `BFR_UCPH_MAX);
				`BFR_OFS_UCSEF:
					next_st.ucSef = clamp(regWrData, `BFR_UCSEF_MIN,
					                      `BFR_UCSEF_MAX);
				default: ;
			endcase
		end

		// Read data stands in the cycle after the strobe only
		next_st.rdData = '0;
		if (regRd)
		begin
			unique case (regAddr)
				`BFR_OFS_CTRL:   next_st.rdData = ctrlWord;
				`BFR_OFS_DLY1:   next_st.rdData = st.dly1;
				`BFR_OFS_DLY2:   next_st.rdData = st.dly2;
				`BFR_OFS_UCPH:   next_st.rdData = st.ucPh;
				`BFR_OFS_UCSEF:  next_st.rdData = st.ucSef;
				`BFR_OFS_STATUS: next_st.rdData = statusWord;
				default:         next_st.rdData = '0;
			endcase
		end

		// Initiation latches; a new trip wins over a reset
		// A trip held high keeps its latch set; the reset acts once it drops
		if (curReset)
			next_st.curInit = 1'b0;
		if (sefReset)
			next_st.sefInit = 1'b0;
		if (extReset)
			next_st.extInit = 1'b0;
		if (currentTrip)
			next_st.curInit = 1'b1;
		if (sefTrip)
			next_st.sefInit = 1'b1;
		if (extTrip)
			next_st.extInit = 1'b1;

		// Step prescaler restarts while idle so delays begin at the trip
		// The first step tick therefore lands one full step after the latch
		next_st.tick = 1'b0;
		if (!active)
			next_st.prescale = '0;
		else if (st.prescale == PRE_LAST)
		begin
			next_st.prescale = '0;
			next_st.tick     = 1'b1;
		end
		else
			next_st.prescale = st.prescale + `BFR_PRE_W'(1);

		// Failure outputs follow the timers
		// One flop behind the timers so the ports leave a flip-flop
		next_st.fail1 = tmr1Expired;
		next_st.fail2 = tmr2Expired;

		// Start withdrawal after any breaker-fail timeout
		next_st.ocStart = ocStartIn &
		                  ~(st.remOc & (tmr1Expired | tmr2Expired));
		next_st.efStart = efStartIn &
		                  ~(st.remEf & (tmr1Expired | tmr2Expired));
	end

	// ======================================================================
	// State register with documented settings at reset
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			st        <= '0;
			st.en1    <= 1'(`BFR_CTRL_RST >> `BFR_CTRL_EN1);
			st.en2    <= 1'b0;
			st.remOc  <= 1'b0;
			st.remEf  <= 1'b0;
			st.extSel <= BFR_EXT_UC_ONLY;
			st.dly1   <= `BFR_DLY1_RST;
			st.dly2   <= `BFR_DLY2_RST;
			st.ucPh   <= `BFR_UCPH_RST;
			st.ucSef  <= `BFR_UCSEF_RST;
		end
		else
			st <= next_st;
	end

	// ======================================================================
	// Outputs straight from flip-flops
	assign regRdData     = st.rdData;
	assign firstFailure  = st.fail1;
	assign secondFailure = st.fail2;
	assign ocStart       = st.ocStart;
	assign efStart       = st.efStart;

endmodule : bfr_breaker_fail

// ===== dv/bfr_breaker_model.sv
/* Model of the breaker poles and of an external protection trip contact.
   Assumes commands from the bench on ref_clk and an active-high reset. */
`timescale 1ns/10ps

module bfr_breaker_model #(
	parameter int POLE_LAG = 3
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       tripCmd,
	input  wire logic       openCmd,
	output logic            extTrip,
	output logic [2:0]      breakerOpen
);
	int lag;

	// ======================================================================
	// Trip contact, and poles that open one after another (slow breaker)
	always_ff @(posedge ref_clk)
	begin
		extTrip <= tripCmd & !srst;
		if (srst || !openCmd)
			lag <= 0;
		else if (lag < 3 * POLE_LAG)
			lag <= lag + 1;
		breakerOpen <= {lag >= 3 * POLE_LAG, lag >= 2 * POLE_LAG, lag >= POLE_LAG};
	end
endmodule : bfr_breaker_model

// ===== dv/bfr_checker_sva.sv
/* Port checker of the breaker-failure supervisor.
   Assumes a bind into bfr_breaker_fail, one clock, synchronous reset. */
`timescale 1ns/10ps
`include "bfr_consts.svh"

module bfr_checker_sva #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic                   ref_clk,
	input wire logic                   srst,
	input wire logic [`BFR_ADDR_W-1:0] regAddr,
	input wire logic                   regWr,
	input wire logic                   regRd,
	input wire logic [`BFR_DATA_W-1:0] regRdData,
	input wire logic                   currentTrip,
	input wire logic                   sefTrip,
	input wire logic                   extTrip,
	input wire logic                   ocStartIn,
	input wire logic                   efStartIn,
	input wire logic                   firstFailure,
	input wire logic                   secondFailure,
	input wire logic                   ocStart,
	input wire logic                   efStart
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ======================================================================
	// Status read and its answer cycle
	sequence statusRead;
		regRd && regAddr == `BFR_OFS_STATUS ##1 1'b1;
	endsequence

	// Start seen, then no timer expired
	sequence ocIdle;
		ocStartIn ##1 (!firstFailure && !secondFailure);
	endsequence

	sequence efIdle;
		efStartIn ##1 (!firstFailure && !secondFailure);
	endsequence

	a_rd_idle_zero: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_status_fail_bits: assert property (statusRead |->
		regRdData[3:0] == $past({efStart, ocStart, secondFailure, firstFailure}))
		else $error("status bits differ from outputs");
	a_oc_low_passes: assert property (!ocStartIn |=> !ocStart)
		else $error("overcurrent start without input");
	a_ef_low_passes: assert property (!efStartIn |=> !efStart)
		else $error("earth start without input");
	a_oc_kept_idle: assert property (ocIdle |-> ocStart)
		else $error("overcurrent start withdrawn without timeout");
	a_ef_kept_idle: assert property (efIdle |-> efStart)
		else $error("earth start withdrawn without timeout");
	a_fail_drop_cause: assert property ($fell(firstFailure) |->
		(!$past(currentTrip, 3) && !$past(sefTrip, 3) && !$past(extTrip, 3))
		|| $past(regWr) || $past(regWr, 2) || $past(regWr, 3))
		else $error("failure dropped while a trip was present");
	a_reset_quiet: assert property ($fell(srst) |-> !firstFailure
		&& !secondFailure && !ocStart && !efStart && regRdData == 16'h0000)
		else $error("outputs not quiet after reset");
endmodule : bfr_checker_sva

// ===== dv/tb_top.sv
/* Bench of the breaker-failure supervisor: registers, timers, resets, starts.
   Assumes the breaker model and the checker files are compiled first. */
`timescale 1ns/10ps

module tb_top;
	localparam int          T = 4;
	localparam logic [15:0] LD = 16'h000a;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdData;
	logic [15:0] magA = LD, magB = LD, magC = LD, magN = LD, magS = 16'h0050;
	logic        curTrip = 1'b0, sefTrip = 1'b0, tripCmd = 1'b0, openCmd = 1'b0;
	logic        ocIn = 1'b0, efIn = 1'b0;
	logic        extTrip, firstFailure, secondFailure, ocStart, efStart;
	logic [2:0]  breakerOpen;
	int          err_total = 0;
	int          num_checks = 0;
	int          n;

	// ======================================================================
	// Clock and instances
	always #50 ref_clk = ~ref_clk;

	bfr_breaker_fail #(.TICK_CYCLES(T)) dut_u (.ref_clk(ref_clk), .srst(srst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .phaseAMag(magA), .phaseBMag(magB), .phaseCMag(magC),
		.neutralMag(magN), .sefMag(magS), .currentTrip(curTrip), .sefTrip(sefTrip),
		.extTrip(extTrip), .breakerOpen(breakerOpen), .ocStartIn(ocIn),
		.efStartIn(efIn), .firstFailure(firstFailure), .secondFailure(secondFailure),
		.ocStart(ocStart), .efStart(efStart));

	bfr_breaker_model brk_u (.ref_clk(ref_clk), .srst(srst), .tripCmd(tripCmd),
		.openCmd(openCmd), .extTrip(extTrip), .breakerOpen(breakerOpen));

	// ======================================================================
	// Shared tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task cycles(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask : cycles

	task bus(input logic rd, input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regRd <= rd;
		regWr <= !rd;
		@(posedge ref_clk);
		regRd <= 1'b0;
		regWr <= 1'b0;
		#1;
	endtask : bus

	task rd(input logic [7:0] a, input logic [15:0] exp);
		bus(1'b1, a, 16'h0000);
		chk(regRdData, exp);
	endtask : rd

	// Undercurrent per phase bit, magnitudes sit on the threshold otherwise
	task cur(input logic [3:0] uc, input logic s);
		@(posedge ref_clk);
		magA <= uc[0] ? 16'h0009 : LD;
		magB <= uc[1] ? 16'h0009 : LD;
		magC <= uc[2] ? 16'h0009 : LD;
		magN <= uc[3] ? 16'h0009 : LD;
		magS <= s ? 16'h004f : 16'h0050;
	endtask : cur

	// One-cycle trip: current, earth or external through the model
	task pulse(input logic c, input logic s);
		@(posedge ref_clk);
		curTrip <= c;
		sefTrip <= s;
		tripCmd <= !c && !s;
		@(posedge ref_clk);
		curTrip <= 1'b0;
		sefTrip <= 1'b0;
		tripCmd <= 1'b0;
		#1;
	endtask : pulse

	task failAt(input int d);
		n = 0;
		while (firstFailure !== 1'b1 && n < 200)
		begin
			cycles(1);
			n++;
		end
		chk(16'(n), 16'(d == 0 ? 2 : d * T + 3));
	endtask : failAt

	// ======================================================================
	// Scenarios
	task automatic t_regs;
		logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
		logic [15:0] e [6] = '{16'h0001, 16'h0014, 16'h0028, 16'h000a, 16'h0050, 16'h0};
		logic [15:0] w [6] = '{16'hffff, 16'h03e8, 16'h0, 16'hffff, 16'h0, 16'hffff};
		logic [15:0] x [6] = '{16'h03e8, 16'h03e8, 16'h0002, 16'h0140, 16'h0004, 16'h0c80};
		logic [7:0]  ca [6] = '{8'h04, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h10};
		bus(1'b0, 8'h18, 16'hffff);
		for (int i = 0; i < 6; i++)
			rd(a[i], e[i]);
		bus(1'b0, 8'h14, 16'hffff);
		rd(8'h14, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b0, ca[i], w[i]);
			rd(ca[i], x[i]);
		end
		bus(1'b0, 8'h0c, 16'h000a);
		bus(1'b0, 8'h10, 16'h0050);
		$display("register test done");
	endtask : t_regs

	task t_cur;
		bus(1'b0, 8'h04, 16'h0002);
		pulse(1'b1, 1'b0);
		failAt(2);
		cycles(20);
		chk(firstFailure, 1'b1);
		chk(secondFailure, 1'b0);
		cur(4'h7, 1'b1);
		cycles(6);
		chk(firstFailure, 1'b1);
		cur(4'hf, 1'b0);
		cycles(4);
		chk(firstFailure, 1'b0);
		cur(4'h0, 1'b0);
		$display("current test done");
	endtask : t_cur

	task t_two;
		bus(1'b0, 8'h00, 16'h0003);
		bus(1'b0, 8'h04, 16'h0000);
		bus(1'b0, 8'h08, 16'h0001);
		pulse(1'b1, 1'b0);
		failAt(0);
		chk(secondFailure, 1'b0);
		cycles(T + 1);
		chk(secondFailure, 1'b1);
		bus(1'b0, 8'h00, 16'h0001);
		cycles(3);
		chk({firstFailure, secondFailure}, 2'b10);
		cur(4'hf, 1'b0);
		cycles(4);
		chk(firstFailure, 1'b0);
		cur(4'h0, 1'b0);
		bus(1'b0, 8'h00, 16'h0000);
		pulse(1'b1, 1'b0);
		cycles(10);
		chk(firstFailure, 1'b0);
		cur(4'hf, 1'b0);
		cur(4'h0, 1'b0);
		$display("two timer test done");
	endtask : t_two

	task t_sef;
		bus(1'b0, 8'h00, 16'h0001);
		pulse(1'b0, 1'b1);
		failAt(0);
		cur(4'hf, 1'b0);
		cycles(6);
		chk(firstFailure, 1'b1);
		cur(4'hf, 1'b1);
		cycles(4);
		chk(firstFailure, 1'b0);
		cur(4'h0, 1'b0);
		$display("earth test done");
	endtask : t_sef

	task t_ext;
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b0, 8'h00, {10'h000, 2'(s), 4'h1});
			pulse(1'b0, 1'b0);
			cycles(6);
			chk(firstFailure, 1'b1);
			@(posedge ref_clk);
			openCmd <= 1'b1;
			cycles(12);
			chk(firstFailure, 1'b1);
			@(posedge ref_clk);
			openCmd <= 1'b0;
			cycles(2);
			cur(4'hf, 1'b0);
			cycles(5);
			chk(firstFailure, 16'(s == 2));
			@(posedge ref_clk);
			openCmd <= 1'b1;
			cycles(14);
			chk(firstFailure, 1'b0);
			@(posedge ref_clk);
			openCmd <= 1'b0;
			cur(4'h0, 1'b0);
		end
		$display("external test done");
	endtask : t_ext

	task t_start;
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b0, 8'h00, k ? 16'h0009 : 16'h0005);
			@(posedge ref_clk);
			ocIn <= 1'b1;
			efIn <= 1'b1;
			cycles(2);
			chk({ocStart, efStart}, 2'b11);
			pulse(1'b1, 1'b0);
			cycles(4);
			chk({ocStart, efStart}, k ? 2'b10 : 2'b01);
			rd(8'h14, k ? 16'h0015 : 16'h0019);
			cur(4'hf, 1'b0);
			cycles(5);
			chk({ocStart, efStart}, 2'b11);
			cur(4'h0, 1'b0);
			@(posedge ref_clk);
			ocIn <= 1'b0;
			efIn <= 1'b0;
		end
		$display("start removal test done");
	endtask : t_start

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// ======================================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		cycles(1);
		t_regs();
		t_cur();
		t_two();
		t_sef();
		t_ext();
		t_start();
		summarize();
	end

	initial
	begin
		#(20000 * 100);
		err_total++;
		summarize();
	end
endmodule : tb_top

bind bfr_breaker_fail bfr_checker_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (
	.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .currentTrip(currentTrip),
	.sefTrip(sefTrip), .extTrip(extTrip), .ocStartIn(ocStartIn),
	.efStartIn(efStartIn), .firstFailure(firstFailure),
	.secondFailure(secondFailure), .ocStart(ocStart), .efStart(efStart));
